// ==== inc/timer_map.vh ====
/*
  Constants of the three-channel interval timer: port offsets on the
  register bus, control word fields, access and mode codes, reset values.
  Assumes inclusion by bare name from the design file only.
*/
// Functional notes
// - Count zero means 65536 steps, mode 0 minimum one
// - Modes 2/3 minimum two; mode 3 one gives 65537
// - Mode 0: low on programming, count after full write
// - Mode 0: high at terminal count until reprogrammed
// - Mode 0: gate low holds count, high resumes
// - Mode 0 one byte: rewrite restarts next clock
// - Mode 0 two bytes: low byte halts, high restarts
// - Mode 1: gate rise drives output low, high at end
// - Mode 1: gate ignored once triggered; retrigger reloads
// - Mode 2: high on programming, starts by write or gate
// - Mode 2: one-clock low pulse every n clocks
// - Mode 2: new count after current period ends
// - Mode 2: gate low forces high, rise restarts
// - Mode 3: square wave, odd n high one longer
// - Mode 3: new count at next output transition
// - Mode 3: gate behaviour same as mode 2
// - Mode 4: one-clock low strobe at terminal count
// - Mode 4: gate return reloads programmed count
// - Mode 5: gate triggered like mode 1, strobe output
// - Count down by one, by two in mode 3
// - Latch command captures count without disturbing it
// - Control word: select, access, mode, decimal bit
// - Access codes: latch, low, high, low then high
// - Decimal bit selects four BCD decades, else binary
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH

// Bus byte offsets of the four ports
`define OFS_CNT0 8'h00
`define OFS_CNT1 8'h04
`define OFS_CNT2 8'h08
`define OFS_CTRL 8'h0C

// Control word fields
`define CW_SEL_HI 7
`define CW_SEL_LO 6
`define CW_ACC_HI 5
`define CW_ACC_LO 4
`define CW_MODE_HI 3
`define CW_MODE_LO 1
`define CW_BCD 0

// Byte access codes
`define ACC_LATCH 2'h0
`define ACC_LOW 2'h1
`define ACC_HIGH 2'h2
`define ACC_BOTH 2'h3

// Operating modes after normalising
`define MODE_0 3'h0
`define MODE_1 3'h1
`define MODE_2 3'h2
`define MODE_3 3'h3
`define MODE_4 3'h4
`define MODE_5 3'h5

// Reset values
`define RST_MODE 3'h0
`define RST_ACC 2'h1
`define RST_CNT 16'h0000
`define RST_OUT 1'b0

`endif

// ==== design/three_channel_interval_timer.v ====
/*
  Three independent 16-bit down-counters with six modes, binary or BCD,
  programmed through an AHB-Lite slave with four 8-bit ports.
  Assumes a single AHB-Lite master; counting clocks and gates are
  asynchronous pins and are sampled through two flip-flops on mclk.
*/
`timescale 1ns/1ps
`include "timer_map.vh"

module three_channel_interval_timer (
  // Clock, reset, enable
  input wire mclk,
  input wire rst,
  input wire ce,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Counter pins
  input wire [2:0] counting_clock_input,
  input wire [2:0] trigger_gate_input,
  output reg [2:0] counter_output_pin
);

  // ****************************************
  // Helpers
  // ****************************************
  // Returns {hit, port}: port 0..2 counters, 3 control word
  function [2:0] port_decode;
    input [7:0] a;
    begin
      if (a == `OFS_CNT0) begin
        port_decode = 3'h4;
      end else if (a == `OFS_CNT1) begin
        port_decode = 3'h5;
      end else if (a == `OFS_CNT2) begin
        port_decode = 3'h6;
      end else if (a == `OFS_CTRL) begin
        port_decode = 3'h7;
      end else begin
        port_decode = 3'h0;
      end
    end
  endfunction

  // Down-count by step, binary wraps at 16 bits, BCD at 9999
  function [15:0] count_down;
    input [15:0] v;
    input [1:0] step;
    input bcd;
    integer k;
    integer d;
    integer b;
    reg [15:0] r;
    begin
      r = 16'h0000;
      b = step;
      for (k = 0; k < 4; k = k + 1) begin
        d = v[k*4 +: 4];
        d = d - b;
        if (d < 0) begin
          d = d + 10;
          b = 1;
        end else begin
          b = 0;
        end
        r[k*4 +: 4] = d[3:0];
      end
      if (bcd) begin
        count_down = r;
      end else begin
        count_down = v - {14'h0000, step};
      end
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg [2:0] mode_reg [0:2];
  reg [1:0] acc_reg [0:2];
  reg [15:0] cnt_reg [0:2];
  reg [15:0] cr_reg [0:2];
  reg [15:0] latch_reg [0:2];
  reg [2:0] bcd_reg;
  reg [2:0] latched_reg;
  reg [2:0] rd_hi_reg;
  reg [2:0] wr_hi_reg;
  reg [2:0] run_reg;
  reg [2:0] load_reg;
  reg [2:0] have_cr_reg;
  reg [2:0] trig_reg;
  reg [2:0] strobe_reg;
  reg [2:0] cclk_s1_reg;
  reg [2:0] cclk_s2_reg;
  reg [2:0] cclk_d_reg;
  reg [2:0] gate_s1_reg;
  reg [2:0] gate_s2_reg;
  reg [2:0] gate_d_reg;
  reg wr_pend_reg;
  reg [1:0] wr_port_reg;
  reg [15:0] dn_val [0:2];
  reg [2:0] toggle_m3;
  reg [2:0] a_dec;
  reg [7:0] rbyte;
  reg [15:0] rsrc;
  reg [2:0] cw_mode;
  integer i;
  integer ch;

  wire [2:0] tick = cclk_s2_reg & ~cclk_d_reg;
  wire [2:0] grise = gate_s2_reg & ~gate_d_reg;
  wire [2:0] gate = gate_s2_reg;
  wire addr_ok = hsel & hready & htrans[1];
  wire [7:0] wd = hwdata[7:0];
  wire [1:0] wsel = wd[`CW_SEL_HI:`CW_SEL_LO];
  wire [1:0] wacc = wd[`CW_ACC_HI:`CW_ACC_LO];

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ****************************************
  // Next count per channel
  // ****************************************
  always @* begin
    for (ch = 0; ch < 3; ch = ch + 1) begin
      if (mode_reg[ch] == `MODE_3) begin
        // Odd count: first step 1 on high half, 3 on low half
        if (cnt_reg[ch][0]) begin
          dn_val[ch] = count_down(cnt_reg[ch], counter_output_pin[ch] ? 2'd1 : 2'd3, bcd_reg[ch]);
        end else begin
          dn_val[ch] = count_down(cnt_reg[ch], 2'd2, bcd_reg[ch]);
        end
        // A first step of 1 landing on zero is no transition: count 1 acts as 10001H
        toggle_m3[ch] = (dn_val[ch] == 16'h0000) && !(cnt_reg[ch][0] && counter_output_pin[ch]);
      end else begin
        dn_val[ch] = count_down(cnt_reg[ch], 2'd1, bcd_reg[ch]);
        toggle_m3[ch] = 1'b0;
      end
    end
    a_dec = port_decode(haddr[7:0]);
    rsrc = latched_reg[a_dec[1:0] == 2'h3 ? 0 : a_dec[1:0]] ?
      latch_reg[a_dec[1:0] == 2'h3 ? 0 : a_dec[1:0]] : cnt_reg[a_dec[1:0] == 2'h3 ? 0 : a_dec[1:0]];
    case (acc_reg[a_dec[1:0] == 2'h3 ? 0 : a_dec[1:0]])
      `ACC_HIGH: rbyte = rsrc[15:8];
      `ACC_BOTH: rbyte = rd_hi_reg[a_dec[1:0] == 2'h3 ? 0 : a_dec[1:0]] ? rsrc[15:8] : rsrc[7:0];
      default: rbyte = rsrc[7:0];
    endcase
    // Modes 6 and 7 fold onto 2 and 3
    cw_mode = wd[2] ? {1'b0, wd[2:1]} : wd[`CW_MODE_HI:`CW_MODE_LO];
  end

  // ****************************************
  // Sequential logic
  // ****************************************
  always @(posedge mclk) begin
    if (rst) begin
      for (i = 0; i < 3; i = i + 1) begin
        mode_reg[i] <= `RST_MODE;
        acc_reg[i] <= `RST_ACC;
        cnt_reg[i] <= `RST_CNT;
        cr_reg[i] <= `RST_CNT;
        latch_reg[i] <= `RST_CNT;
      end
      bcd_reg <= 3'h0;
      latched_reg <= 3'h0;
      rd_hi_reg <= 3'h0;
      wr_hi_reg <= 3'h0;
      run_reg <= 3'h0;
      load_reg <= 3'h0;
      have_cr_reg <= 3'h0;
      trig_reg <= 3'h0;
      strobe_reg <= 3'h0;
      counter_output_pin <= {3{`RST_OUT}};
      cclk_s1_reg <= 3'h0;
      cclk_s2_reg <= 3'h0;
      cclk_d_reg <= 3'h0;
      gate_s1_reg <= 3'h0;
      gate_s2_reg <= 3'h0;
      gate_d_reg <= 3'h0;
      wr_pend_reg <= 1'b0;
      wr_port_reg <= 2'h0;
      hrdata <= 32'h00000000;
    end else if (ce) begin
      cclk_s1_reg <= counting_clock_input;
      cclk_s2_reg <= cclk_s1_reg;
      cclk_d_reg <= cclk_s2_reg;
      gate_s1_reg <= trigger_gate_input;
      gate_s2_reg <= gate_s1_reg;
      gate_d_reg <= gate_s2_reg;

      // Each channel runs from its own clock and gate
      for (i = 0; i < 3; i = i + 1) begin
        if (tick[i]) begin
          trig_reg[i] <= 1'b0;
          case (mode_reg[i])
            `MODE_0, `MODE_4: begin
              if (load_reg[i]) begin
                cnt_reg[i] <= cr_reg[i];
                load_reg[i] <= 1'b0;
                run_reg[i] <= 1'b1;
                strobe_reg[i] <= 1'b0;
                if (mode_reg[i] == `MODE_0) begin
                  counter_output_pin[i] <= 1'b0;
                end else begin
                  counter_output_pin[i] <= 1'b1;
                end
              end else if (strobe_reg[i]) begin
                counter_output_pin[i] <= 1'b1;
                strobe_reg[i] <= 1'b0;
                run_reg[i] <= 1'b0;
              end else if (run_reg[i] && gate[i]) begin
                if (mode_reg[i] == `MODE_4 && trig_reg[i]) begin
                  cnt_reg[i] <= cr_reg[i];
                end else begin
                  cnt_reg[i] <= dn_val[i];
                  if (dn_val[i] == 16'h0000) begin
                    if (mode_reg[i] == `MODE_0) begin
                      counter_output_pin[i] <= 1'b1;
                    end else begin
                      counter_output_pin[i] <= 1'b0;
                      strobe_reg[i] <= 1'b1;
                    end
                  end
                end
              end
            end
            `MODE_1, `MODE_5: begin
              if (trig_reg[i] && have_cr_reg[i]) begin
                cnt_reg[i] <= cr_reg[i];
                run_reg[i] <= 1'b1;
                strobe_reg[i] <= 1'b0;
                counter_output_pin[i] <= (mode_reg[i] == `MODE_5);
              end else if (strobe_reg[i]) begin
                counter_output_pin[i] <= 1'b1;
                strobe_reg[i] <= 1'b0;
                run_reg[i] <= 1'b0;
              end else if (run_reg[i]) begin
                cnt_reg[i] <= dn_val[i];
                if (dn_val[i] == 16'h0000) begin
                  if (mode_reg[i] == `MODE_1) begin
                    counter_output_pin[i] <= 1'b1;
                    run_reg[i] <= 1'b0;
                  end else begin
                    counter_output_pin[i] <= 1'b0;
                    strobe_reg[i] <= 1'b1;
                  end
                end
              end
            end
            default: begin
              // Modes 2 and 3
              if (gate[i] && have_cr_reg[i] && (trig_reg[i] || (load_reg[i] && !run_reg[i]))) begin
                cnt_reg[i] <= cr_reg[i];
                load_reg[i] <= 1'b0;
                run_reg[i] <= 1'b1;
                counter_output_pin[i] <= 1'b1;
              end else if (run_reg[i] && gate[i]) begin
                if (mode_reg[i] == `MODE_2) begin
                  if (cnt_reg[i] == 16'h0001) begin
                    cnt_reg[i] <= cr_reg[i];
                    load_reg[i] <= 1'b0;
                    counter_output_pin[i] <= 1'b1;
                  end else begin
                    cnt_reg[i] <= dn_val[i];
                    if (dn_val[i] == 16'h0001) begin
                      counter_output_pin[i] <= 1'b0;
                    end
                  end
                end else if (toggle_m3[i]) begin
                  cnt_reg[i] <= cr_reg[i];
                  load_reg[i] <= 1'b0;
                  counter_output_pin[i] <= ~counter_output_pin[i];
                end else begin
                  cnt_reg[i] <= dn_val[i];
                end
              end
            end
          endcase
        end
        if (grise[i]) begin
          trig_reg[i] <= 1'b1;
        end
        if ((mode_reg[i] == `MODE_2 || mode_reg[i] == `MODE_3) && !gate[i]) begin
          counter_output_pin[i] <= 1'b1;
          run_reg[i] <= 1'b0;
        end
      end

      // Bus address phase
      wr_pend_reg <= addr_ok & hwrite & a_dec[2];
      wr_port_reg <= a_dec[1:0];
      if (addr_ok && !hwrite) begin
        if (a_dec[2] && a_dec[1:0] != 2'h3) begin
          hrdata <= {24'h000000, rbyte};
          if (acc_reg[a_dec[1:0]] == `ACC_BOTH) begin
            rd_hi_reg[a_dec[1:0]] <= ~rd_hi_reg[a_dec[1:0]];
          end
          if (acc_reg[a_dec[1:0]] != `ACC_BOTH || rd_hi_reg[a_dec[1:0]]) begin
            latched_reg[a_dec[1:0]] <= 1'b0;
          end
        end else begin
          hrdata <= 32'h00000000;
        end
      end

      // Bus data phase: write
      if (wr_pend_reg) begin
        if (wr_port_reg == 2'h3) begin
          if (wsel != 2'h3) begin
            if (wacc == `ACC_LATCH) begin
              if (!latched_reg[wsel]) begin
                latch_reg[wsel] <= cnt_reg[wsel];
                latched_reg[wsel] <= 1'b1;
                rd_hi_reg[wsel] <= 1'b0;
              end
            end else begin
              mode_reg[wsel] <= cw_mode;
              acc_reg[wsel] <= wacc;
              bcd_reg[wsel] <= wd[`CW_BCD];
              counter_output_pin[wsel] <= (cw_mode != `MODE_0);
              cnt_reg[wsel] <= `RST_CNT;
              run_reg[wsel] <= 1'b0;
              load_reg[wsel] <= 1'b0;
              have_cr_reg[wsel] <= 1'b0;
              trig_reg[wsel] <= 1'b0;
              strobe_reg[wsel] <= 1'b0;
              wr_hi_reg[wsel] <= 1'b0;
              rd_hi_reg[wsel] <= 1'b0;
              latched_reg[wsel] <= 1'b0;
            end
          end
        end else begin
          case (acc_reg[wr_port_reg])
            `ACC_LOW: begin
              cr_reg[wr_port_reg] <= {8'h00, wd};
            end
            `ACC_HIGH: begin
              cr_reg[wr_port_reg] <= {wd, 8'h00};
            end
            default: begin
              if (!wr_hi_reg[wr_port_reg]) begin
                cr_reg[wr_port_reg][7:0] <= wd;
              end else begin
                cr_reg[wr_port_reg][15:8] <= wd;
              end
              wr_hi_reg[wr_port_reg] <= ~wr_hi_reg[wr_port_reg];
            end
          endcase
          if (acc_reg[wr_port_reg] != `ACC_BOTH || wr_hi_reg[wr_port_reg]) begin
            have_cr_reg[wr_port_reg] <= 1'b1;
            load_reg[wr_port_reg] <= 1'b1;
          end
          if (mode_reg[wr_port_reg] == `MODE_0) begin
            run_reg[wr_port_reg] <= 1'b0;
          end
        end
      end
    end
  end

endmodule

// ==== bench/timer_port_checker_sva.sv ====
/* Port checker of the interval timer: bus answers and output levels.
   Assumes one master with no pipelined transfers and ce held high. */
`timescale 1ns/1ps
module timer_port_checker (
  // Clock, reset
  input wire mclk,
  input wire rst,
  // Bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // Counter pins
  input wire [2:0] counting_clock_input,
  input wire [2:0] trigger_gate_input,
  input wire [2:0] counter_output_pin
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  reg ap_reg, wr_reg, ck_reg, out_reg, hold_reg;
  reg [7:0] ofs_reg;
  reg [8:0] mode_reg;
  reg [1:0] edg_reg;
  wire cw = ap_reg && wr_reg && ofs_reg == 8'h0C && hwdata[7:6] != 2'h3 && hwdata[5:4] != 2'h0;
  wire cw0 = cw && hwdata[7:6] == 2'h0;
  wire wr0 = ap_reg && wr_reg && ofs_reg == 8'h00;
  // Shadow of modes, output hold and clock edges seen while channel 1 is low
  always @(posedge mclk) begin
    if (rst) begin
      ap_reg <= 1'b0;
      mode_reg <= 9'h0;
      hold_reg <= 1'b0;
      edg_reg <= 2'h0;
    end else begin
      ap_reg <= hsel && hready && htrans[1];
      if (cw) begin
        mode_reg[hwdata[7:6] * 3 +: 3] <= {hwdata[3] & ~hwdata[2], hwdata[2:1]};
      end
      if (wr0 || cw0) begin
        hold_reg <= 1'b0;
      end else if (mode_reg[2:0] == 3'h0 && counter_output_pin[0] && !out_reg) begin
        hold_reg <= 1'b1;
      end
      if (counter_output_pin[1] || cw) begin
        edg_reg <= 2'h0;
      end else if (counting_clock_input[1] && !ck_reg && edg_reg != 2'h3) begin
        edg_reg <= edg_reg + 2'h1;
      end
    end
    wr_reg <= hwrite;
    ofs_reg <= haddr[7:0];
    ck_reg <= counting_clock_input[1];
    out_reg <= counter_output_pin[0];
  end
  property p_bus_ok; hreadyout && !hresp; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not okay");
  property p_unmapped; hsel && hready && htrans[1] && !hwrite &&
    !(haddr[7:0] inside {8'h00, 8'h04, 8'h08}) |=> hrdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_m0_low; cw0 && hwdata[3:1] == 3'h0 |-> ##[1:2] !counter_output_pin[0]; endproperty
  a_m0_low: assert property (p_m0_low) else $error("mode 0 output not low");
  property p_prog_high; cw0 && hwdata[3:1] != 3'h0 |-> ##[1:2] counter_output_pin[0]; endproperty
  a_prog_high: assert property (p_prog_high) else $error("programmed output not high");
  property p_m0_hold; hold_reg |-> counter_output_pin[0]; endproperty
  a_m0_hold: assert property (p_m0_hold) else $error("mode 0 output fell");
  property p_m2_pulse; mode_reg[5:3] == 3'h2 && !counter_output_pin[1] |-> edg_reg <= 2'h1; endproperty
  a_m2_pulse: assert property (p_m2_pulse) else $error("rate pulse too long");
  property p_m2_gate; (mode_reg[4] && !trigger_gate_input[1]) [*6] |-> counter_output_pin[1]; endproperty
  a_m2_gate: assert property (p_m2_gate) else $error("gated rate output low");
  property p_m3_gate; (mode_reg[7] && !trigger_gate_input[2]) [*6] |-> counter_output_pin[2]; endproperty
  a_m3_gate: assert property (p_m3_gate) else $error("gated square output low");
  c_hold: cover property (hold_reg);
  c_pulse: cover property (mode_reg[5:3] == 3'h2 && !counter_output_pin[1]);
  c_unmapped: cover property (hsel && htrans[1] && !hwrite && haddr[7:0] == 8'h10);
endmodule
bind three_channel_interval_timer timer_port_checker u_chk (.mclk(mclk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .counting_clock_input(counting_clock_input),
  .trigger_gate_input(trigger_gate_input), .counter_output_pin(counter_output_pin));

// ==== bench/timer_host_model.sv ====
/* Host model: single word transfers on the register bus, byte data in bits 7:0.
   Assumes hready comes back from the slave. */
`timescale 1ns/1ps
module timer_host_model (
  // Clock
  input wire mclk,
  // Request
  output reg hsel,
  output reg [31:0] haddr,
  output reg [1:0] htrans,
  output reg hwrite,
  output reg [2:0] hsize,
  output reg [31:0] hwdata,
  // Answer
  input wire hready,
  input wire [31:0] hrdata
);
  reg [31:0] dummy;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  task xfer(input [7:0] a, input w, input [7:0] d, output [31:0] r);
    begin
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      r = hrdata;
      // Released data shows the complement, never the stale byte
      hwdata <= ~{24'h0, d};
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    xfer(a, 1'b1, d, dummy);
  endtask
  task rd(input [7:0] a, output [31:0] r);
    xfer(a, 1'b0, 8'h00, r);
  endtask
  task wr16(input [7:0] a, input [15:0] v);
    begin
      xfer(a, 1'b1, v[7:0], dummy);
      xfer(a, 1'b1, v[15:8], dummy);
    end
  endtask
endmodule

// ==== bench/three_channel_interval_timer_tb.sv ====
/* Bench of the interval timer: random counts in modes 0, 2 and 3, fixed counts in modes 1, 4 and 5, latch, BCD, bus map.
   Assumes the host model and the bound port checker. */
`timescale 1ns/1ps
module three_channel_interval_timer_tb;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg [2:0] cki = 3'h0;
  reg [2:0] gate = 3'h7;
  wire hsel, hwrite, hreadyout, hresp;
  wire [1:0] htrans;
  wire [2:0] hsize, outp;
  wire [31:0] haddr, hwdata, hrdata;
  integer errors = 0;
  integer cmp_count = 0;
  integer seed = 15;
  integer cycles = 0;
  integer n, m, k;
  reg [31:0] q;
  always #5 mclk = ~mclk;
  timer_host_model u_host (.mclk(mclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
  three_channel_interval_timer dut (.mclk(mclk), .rst(rst), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .counting_clock_input(cki),
    .trigger_gate_input(gate), .counter_output_pin(outp));
  function [15:0] dec(input [15:0] v, input b, input integer t);
    integer j, i;
    begin
      for (j = 0; j < t; j = j + 1) begin
        i = 0;
        while (b && i < 4 && v[i * 4 +: 4] == 4'h0) begin
          v[i * 4 +: 4] = 4'h9;
          i = i + 1;
        end
        if (!b) v = v - 16'h1;
        else if (i < 4) v[i * 4 +: 4] = v[i * 4 +: 4] - 4'h1;
      end
      dec = v;
    end
  endfunction
  task summarize;
    begin
      $display("errors=%0d comparisons=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk_val(input string s, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
    end
  endtask
  task tick(input integer c);
    begin
      cki[c] <= 1'b1;
      repeat (4) @(posedge mclk);
      cki[c] <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask
  task set_gate(input integer c, input b);
    begin
      gate[c] <= b;
      repeat (4) @(posedge mclk);
    end
  endtask
  task run_to(input integer c, input b, output integer r);
    begin
      r = 0;
      while (outp[c] !== b && r < 40) begin
        tick(c);
        r = r + 1;
      end
    end
  endtask
  task pin(input string s, input integer c, input b);
    begin
      repeat (3) @(posedge mclk);
      chk_val(s, {31'h0, b}, {31'h0, outp[c]});
    end
  endtask
  task rd_chk(input string s, input [7:0] a, input [15:0] e);
    begin
      u_host.rd(a, q);
      chk_val(s, {24'h0, e[7:0]}, q);
      u_host.rd(a, q);
      chk_val(s, {24'h0, e[15:8]}, q);
    end
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors = errors + 1;
      summarize;
    end
  end
  // ***
  // Scenarios
  // ***
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    n = 1 + ($unsigned($random(seed)) % 8);
    u_host.wr(8'h0C, 8'h10);
    pin("m0 armed", 0, 1'b0);
    u_host.wr(8'h00, n[7:0]);
    tick(0);
    set_gate(0, 1'b0);
    repeat (3) tick(0);
    pin("m0 gated", 0, 1'b0);
    set_gate(0, 1'b1);
    run_to(0, 1'b1, k);
    chk_val("m0 ticks", n, k);
    repeat (3) tick(0);
    pin("m0 held", 0, 1'b1);
    $display("TEST mode0 done");
    u_host.wr(8'h0C, 8'h12);
    pin("m1 armed", 0, 1'b1);
    u_host.wr(8'h00, 8'h03);
    repeat (2) tick(0);
    pin("m1 idle", 0, 1'b1);
    set_gate(0, 1'b0);
    set_gate(0, 1'b1);
    run_to(0, 1'b0, k);
    chk_val("m1 start", 1, k);
    set_gate(0, 1'b0);
    run_to(0, 1'b1, k);
    chk_val("m1 width", 3, k);
    $display("TEST mode1 done");
    n = 2 + ($unsigned($random(seed)) % 8);
    m = 2 + ($unsigned($random(seed)) % 8);
    u_host.wr(8'h0C, 8'h54);
    pin("m2 armed", 1, 1'b1);
    u_host.wr(8'h04, n[7:0]);
    run_to(1, 1'b0, k);
    chk_val("m2 first", n, k);
    run_to(1, 1'b1, k);
    chk_val("m2 low", 1, k);
    u_host.wr(8'h04, m[7:0]);
    run_to(1, 1'b0, k);
    chk_val("m2 old", n - 1, k);
    run_to(1, 1'b1, k);
    run_to(1, 1'b0, k);
    chk_val("m2 new", m - 1, k);
    set_gate(1, 1'b0);
    pin("m2 gated", 1, 1'b1);
    set_gate(1, 1'b1);
    run_to(1, 1'b0, k);
    chk_val("m2 restart", m, k);
    $display("TEST mode2 done");
    n = 3 + 2 * ($unsigned($random(seed)) % 4);
    u_host.wr(8'h0C, 8'h96);
    pin("m3 armed", 2, 1'b1);
    u_host.wr(8'h08, n[7:0]);
    run_to(2, 1'b0, k);
    run_to(2, 1'b1, k);
    chk_val("m3 low", (n - 1) / 2, k);
    run_to(2, 1'b0, k);
    chk_val("m3 high", (n + 1) / 2, k);
    set_gate(2, 1'b0);
    pin("m3 gated", 2, 1'b1);
    $display("TEST mode3 done");
    set_gate(0, 1'b1);
    u_host.wr(8'h0C, 8'h30);
    u_host.wr16(8'h00, 16'h1234);
    repeat (4) tick(0);
    u_host.wr(8'h0C, 8'h00);
    repeat (2) tick(0);
    rd_chk("latched", 8'h00, dec(16'h1234, 1'b0, 3));
    set_gate(0, 1'b0);
    rd_chk("direct", 8'h00, dec(16'h1234, 1'b0, 5));
    set_gate(2, 1'b1);
    u_host.wr(8'h0C, 8'hB1);
    u_host.wr16(8'h08, 16'h1000);
    repeat (2) tick(2);
    set_gate(2, 1'b0);
    rd_chk("bcd", 8'h08, dec(16'h1000, 1'b1, 1));
    $display("TEST latch done");
    u_host.wr(8'h0C, 8'h10);
    set_gate(0, 1'b1);
    u_host.wr(8'h00, 8'h05);
    repeat (3) tick(0);
    u_host.wr(8'h00, 8'h04);
    run_to(0, 1'b1, k);
    chk_val("m0 rewrite", 5, k);
    $display("TEST rewrite done");
    u_host.wr(8'h0C, 8'h58);
    pin("m4 armed", 1, 1'b1);
    u_host.wr(8'h04, 8'h03);
    run_to(1, 1'b0, k);
    chk_val("m4 strobe at", 4, k);
    run_to(1, 1'b1, k);
    chk_val("m4 width", 1, k);
    repeat (3) tick(1);
    pin("m4 once", 1, 1'b1);
    u_host.wr(8'h04, 8'h04);
    repeat (2) tick(1);
    set_gate(1, 1'b0);
    tick(1);
    set_gate(1, 1'b1);
    run_to(1, 1'b0, k);
    chk_val("m4 reload", 5, k);
    $display("TEST mode4 done");
    u_host.wr(8'h0C, 8'h9A);
    u_host.wr(8'h08, 8'h02);
    tick(2);
    pin("m5 untriggered", 2, 1'b1);
    set_gate(2, 1'b1);
    run_to(2, 1'b0, k);
    chk_val("m5 strobe at", 3, k);
    run_to(2, 1'b1, k);
    chk_val("m5 width", 1, k);
    set_gate(2, 1'b0);
    set_gate(2, 1'b1);
    run_to(2, 1'b0, k);
    chk_val("m5 retrigger", 3, k);
    $display("TEST mode5 done");
    u_host.wr(8'h10, 8'hA5);
    u_host.rd(8'h10, q);
    chk_val("unmapped", 32'h0, q);
    u_host.rd(8'h0C, q);
    chk_val("ctrl read", 32'h0, q);
    $display("TEST map done");
    summarize;
  end
endmodule
